// File: sim/csq_master_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module csq_master_seq_properties #(
    parameter int TMO_CYC = 50
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Serial link
    input wire logic        sck,
    input wire logic        mosi,
    input wire logic        busy,
    input wire logic [1:0]  cs_n,
    input wire logic        transfer_irq
);
    int tmo_q;
    int tmo_d;
    // Cycles spent selected while the slave still reports busy; the slack covers the input synchroniser.
    always_comb tmo_d = (cs_n != 2'h3 && busy) ? tmo_q + 1 : 0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tmo_q <= 0;
        else tmo_q <= tmo_d;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_next; psel && !penable |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
    property p_ready_acc; pready |-> psel && penable; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("pready outside access");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_rdata_hold; $changed(prdata) |-> pready; endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved outside access");
    property p_irq_pulse; transfer_irq |=> !transfer_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a pulse");
    property p_irq_idle; transfer_irq |-> sck; endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq while clock low");
    property p_sck_low; $fell(sck) |-> (!sck) [*4] ##1 sck; endproperty
    a_sck_low: assert property (p_sck_low) else $error("clock low phase wrong");
    property p_mosi_rise; $rose(sck) |-> $stable(mosi); endproperty
    a_mosi_rise: assert property (p_mosi_rise) else $error("data moved at rising clock");
    property p_cs_one; cs_n != 2'h0; endproperty
    a_cs_one: assert property (p_cs_one) else $error("both slaves selected");
    property p_cs_tmo; tmo_q <= (TMO_CYC + 8); endproperty
    a_cs_tmo: assert property (p_cs_tmo) else $error("select held past timeout");
endmodule
bind csq_master_seq csq_master_seq_properties #(.TMO_CYC(TMO_CYC)) i_csq_master_seq_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck(sck), .mosi(mosi), .busy(busy), .cs_n(cs_n), .transfer_irq(transfer_irq));
`default_nettype wire

// File: sim/csq_master_seq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module csq_master_seq_tb_top;
    import csq_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, miso, busy, pready, pslverr, sck, mosi, irq, ext_sel, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  cs_n;
    int          mismatches = 0;
    int          tests_run = 0;
    int          irqs = 0;
    csq_master_seq #(.TMO_CYC(50)) i_csq_master_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck(sck), .mosi(mosi), .miso(miso), .busy(busy), .cs_n(cs_n), .transfer_irq(irq));
    csq_slave_model i_csq_slave_model (.sck(sck), .mosi(mosi), .cs_n(cs_n), .ext_sel(ext_sel), .miso(miso),
        .busy(busy));
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) if (irq === 1'b1) irqs++;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_idle;
        int n;
        for (n = 0; n < 300; n++) begin
            apb(1'b0, A_STAT, 32'h0);
            if (rd[8] === 1'b1 && rd[9] === 1'b0 && rd[14] === 1'b0) break;
        end
        chk(32'(n < 300), 32'h1);
    endtask
    // A fresh selection restarts the slave's byte numbering.
    task reframe(input logic on);
        @(posedge pclk);
        ext_sel <= 1'b0;
        repeat (2) @(posedge pclk);
        ext_sel <= on;
    endtask
    task t_reset;
        chk(32'(cs_n), 32'h3);
        chk(32'(sck), 32'h1);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd, 32'h100);
        apb(1'b0, 8'hF0, 32'h0);
        chk(32'(err), 32'h1);
    endtask
    task t_single;
        apb(1'b1, A_CTRL, 32'h1);
        reframe(1'b1);
        apb(1'b1, A_DATA, 32'hA5);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[8:0]), 32'h1);
        wait_idle;
        chk(32'(i_csq_slave_model.rx_log[0]), 32'hA5);
        apb(1'b1, A_CTRL, 32'h2);
        reframe(1'b1);
        apb(1'b1, A_RXGO, 32'h0);
        wait_idle;
        chk(32'(i_csq_slave_model.rx_log[0]), 32'hFF);
        apb(1'b0, A_HOLD, 32'h0);
        chk(rd, 32'h5A);
        apb(1'b1, A_DATA, 32'h11);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[13:0]), 32'h2100);
        apb(1'b1, A_CTRL, 32'h1);
        apb(1'b1, A_STAT, 32'h0);
        apb(1'b1, A_RXGO, 32'h0);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[13:0]), 32'h2100);
        apb(1'b1, A_CTRL, 32'h6);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, A_CTRL, 32'h6);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'h6);
    endtask
    task t_cmd;
        reframe(1'b0);
        for (int k = 1; k < 4; k++) apb(1'b1, 8'h3C + 8'(4 * k), 32'h11 * k);
        for (int op = 0; op < 4; op++) begin
            apb(1'b1, A_CMD, 32'(op));
            wait_idle;
            chk(32'(i_csq_slave_model.rx_log[0]), 32'(op + 1));
            chk(32'(i_csq_slave_model.nbytes), (op == 0) ? 32'h3 : 32'h4);
            for (int k = 1; k < 4; k++) begin
                if (op == 1) chk(32'(i_csq_slave_model.rx_log[k]), 32'h11 * k);
                apb(1'b0, 8'h7C + 8'(4 * k), 32'h0);
                if (op == 2) chk(rd, 32'(8'h5A ^ 8'(k)));
            end
        end
        apb(1'b0, A_SLV, 32'h0);
        chk(32'(rd[15:0]), 32'h0303);
        apb(1'b1, A_CMD, 32'h4);
        wait_idle;
        chk(32'(rd[12]), 32'h1);
        chk(32'(cs_n), 32'h3);
    endtask
    task t_seq;
        int n0;
        apb(1'b1, A_SEQ, 32'h200);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[10]), 32'h1);
        apb(1'b1, A_STAT, 32'h0);
        apb(1'b1, A_SEQ, 32'h300);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[10]), 32'h1);
        reframe(1'b1);
        n0 = irqs;
        apb(1'b1, A_SEQ, 32'h40203);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[7:0]), 32'h3);
        wait_idle;
        chk(32'(irqs - n0), 32'h3);
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 8'h90 + 8'(4 * k), 32'h0);
            chk(rd, 32'(8'h5A ^ 8'(k)));
        end
        apb(1'b1, 8'h60, 32'hC3);
        apb(1'b1, 8'h64, 32'h3C);
        reframe(1'b1);
        n0 = irqs;
        apb(1'b1, A_SEQ, 32'h8102);
        wait_idle;
        chk(32'(irqs - n0), 32'h3);
        chk(32'(i_csq_slave_model.nbytes), 32'h2);
        chk(32'(i_csq_slave_model.rx_log[1]), 32'h3C);
        reframe(1'b1);
        apb(1'b1, A_SEQ, 32'hA8301);
        wait_idle;
        chk(32'(i_csq_slave_model.rx_log[0]), 32'hC3);
        apb(1'b0, 8'hA8, 32'h0);
        chk(rd, 32'h5A);
    endtask
    task summarize;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, ext_sel} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_single;
        t_cmd;
        t_seq;
        summarize;
    end
    // The whole sequence needs well under a quarter of this span.
    initial begin
        #400000;
        mismatches++;
        summarize;
    end
endmodule
`default_nettype wire

// File: sim/csq_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module csq_slave_model
    import csq_pkg::*;
#(
    parameter logic [7:0] TXABLE = 8'h03,
    parameter logic [7:0] RXABLE = 8'h03
) (
    // Link from the master
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic [1:0] cs_n,
    input  wire logic       ext_sel,
    // Answers to the master
    output logic            miso,
    output logic            busy
);
    logic       sel;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] rsp;
    logic [7:0] rx_log [0:15];
    int         nbytes;
    int         bitn;
    assign sel = !cs_n[0] || ext_sel;
    assign rsp = (cmd == CMD_STS && nbytes == 1) ? TXABLE :
                 (cmd == CMD_STS && nbytes == 2) ? RXABLE : 8'h5A ^ nbytes[7:0];
    initial begin
        miso = 1'b1;
        busy = 1'b1;
    end
    // Slave 1 is absent, so its busy line never falls and selecting it must time out.
    always @(sel) begin
        if (sel) begin
            nbytes = 0;
            bitn = 0;
            cmd = 8'h00;
            #30 busy = !sel;
        end else begin
            busy = 1'b1;
            miso = ~miso;
        end
    end
    always @(negedge sck) if (sel) miso = rsp[7 - bitn];
    always @(posedge sck) begin
        if (sel) begin
            sh = {sh[6:0], mosi};
            bitn++;
            if (bitn == 8) begin
                rx_log[nbytes] = sh;
                if (nbytes == 0) cmd = sh;
                nbytes++;
                bitn = 0;
            end
        end
    end
endmodule
`default_nettype wire

// File: src/csq_master_seq.sv
// Operation
// - Writing a transmit byte starts one character; pending count is 1 until done.
// - Single reception writes all-ones dummy byte so clocks run.
// - End of single character captures received byte and clears pending count.
// - Done reads set when pending count is zero, received byte then valid.
// - Continuous reception loads pending count; zero count refused and reported.
// - Continuous transmit or transmit/receive confirms transfer really started.
// - Continuous transmit of two or more uses buffer-empty timing and next handler.
// - Transmit/receive of two or more uses buffer-empty timing, storing and refilling.
// - Transmit/receive takes source, destination and one count; zero count refused.
// - Interrupt timing selectable between end of transfer and buffer empty.
// - Mode change stops channel, enables new mode, timing back to end.
// - Status command returns slave counts; timeout or invalid count flags error.
// - Transmit command sends exactly the count the slave can receive.
// - Receive command collects exactly the count the slave can transmit.
// - Transmit/receive command only when both slave counts are equal.
// - Single reception only in reception or transmit/receive mode.
// - Single transmission only in transmission or transmit/receive mode.
// - Characters are 8 bits, MSB first, clock idle high, sample on rising.
// - After chip select wait busy low; deselect on timeout.
// - Continuous reception decrements count and restarts with dummy while more remain.
// - Continuous transmit with one left switches to end timing, then clears count.
`timescale 1ns/1ps
`default_nettype none
module csq_master_seq
    import csq_pkg::*;
#(
    parameter int DEPTH   = 16,
    parameter int SCK_DIV = csq_pkg::SCK_HALF,
    parameter int TMO_CYC = csq_pkg::BUSY_TMO_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    output logic             sck,
    output logic             mosi,
    input  wire logic        miso,
    input  wire logic        busy,
    output logic      [1:0]  cs_n,
    output logic             transfer_irq
);
    import csq_pkg::*;
    localparam int AW = $clog2(DEPTH);

    logic [7:0] tbuf [DEPTH];
    logic [7:0] rbuf [DEPTH];
    logic miso_m, miso_s, busy_m, busy_s;
    // Engine state.
    logic [7:0] sh_q, sh_d, hold_q, hold_d, rx_q, rx_d, div_q, div_d;
    logic [2:0] bit_q, bit_d;
    logic run_q, run_d, hv_q, hv_d, sck_q, sck_d, mosi_q, mosi_d, rxr_q, rxr_d, irq_q, irq_d;
    logic emp_e, end_e, tick;
    // Control state.
    csq_mode_t mode_q, mode_d, newm, gk;
    csq_hnd_t  hnd_q, hnd_d;
    csq_st_t   st_q, st_d;
    csq_op_t   op_q, op_d;
    logic tim_q, tim_d, zero_q, zero_d, serr_q, serr_d, cerr_q, cerr_d, ill_q, ill_d;
    logic chk_q, chk_d, sel_q, sel_d;
    logic [7:0] cnt_q, cnt_d, holdrx_q, holdrx_d, gn, cur_tx, cur_rx;
    logic [15:0] slave_count_first_q, slave_count_first_d, slave_count_second_q, slave_count_second_d;
    logic [AW-1:0] txp_q, txp_d, rxp_q, rxp_d, gtp, grp;
    logic [31:0] tmo_q, tmo_d, rd;
    logic [1:0] csn_q, csn_d;
    logic ld, abort, rxclr, go, chmode, wr, rw_en, tw_en, bad;
    logic [7:0] ldb;

    // Pins from the slave cross into pclk through two flops each.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_m <= 1'b1;
            miso_s <= 1'b1;
            busy_m <= 1'b1;
            busy_s <= 1'b1;
        end else begin
            miso_m <= miso;
            miso_s <= miso_m;
            busy_m <= busy;
            busy_s <= busy_m;
        end
    end

    // Shift engine with one character of transmit buffering.
    always_comb begin
        sh_d   = sh_q;
        hold_d = hold_q;
        rx_d   = rx_q;
        bit_d  = bit_q;
        run_d  = run_q;
        hv_d   = hv_q;
        sck_d  = sck_q;
        mosi_d = mosi_q;
        rxr_d  = rxr_q & ~rxclr;
        emp_e  = 1'b0;
        end_e  = 1'b0;
        tick   = div_q == 8'(SCK_DIV - 1);
        div_d  = (run_q && !tick) ? div_q + 8'h01 : 8'h00;
        if (!run_q && hv_q) begin
            sh_d  = hold_q;
            hv_d  = 1'b0;
            run_d = 1'b1;
            bit_d = 3'h0;
            emp_e = 1'b1;
        end else if (run_q && tick) begin
            sck_d = ~sck_q;
            if (sck_q) begin
                mosi_d = sh_q[7];
            end else begin
                sh_d  = {sh_q[6:0], miso_s};
                bit_d = bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    rx_d  = {sh_q[6:0], miso_s};
                    rxr_d = 1'b1;
                    // Refill straight from the buffer so back-to-back characters keep the clock running.
                    if (hv_q) begin
                        sh_d  = hold_q;
                        hv_d  = 1'b0;
                        emp_e = 1'b1;
                    end else begin
                        run_d = 1'b0;
                        end_e = 1'b1;
                    end
                end
            end
        end
        if (abort) begin
            run_d = 1'b0;
            hv_d  = 1'b0;
            sck_d = 1'b1;
        end
        if (ld) begin
            hold_d = ldb;
            hv_d   = 1'b1;
        end
        irq_d = tim_q ? emp_e : end_e;
    end

    always_comb begin
        cur_tx = sel_q ? slave_count_second_q[15:8] : slave_count_first_q[15:8];
        cur_rx = sel_q ? slave_count_second_q[7:0] : slave_count_first_q[7:0];
        wr     = psel & penable & pwrite & pready;
        mode_d = mode_q; tim_d = tim_q; hnd_d = hnd_q; cnt_d = cnt_q; holdrx_d = holdrx_q;
        txp_d = txp_q; rxp_d = rxp_q; chk_d = 1'b0; st_d = st_q; op_d = op_q; sel_d = sel_q;
        csn_d = csn_q; tmo_d = tmo_q; zero_d = zero_q; serr_d = serr_q; cerr_d = cerr_q; ill_d = ill_q;
        slave_count_first_d = slave_count_first_q; slave_count_second_d = slave_count_second_q;
        ld = 1'b0; ldb = DUMMY; abort = 1'b0; rxclr = 1'b0; go = 1'b0; gk = M_TX; gn = 8'h00;
        gtp = txp_q; grp = rxp_q; newm = mode_q; rw_en = 1'b0; tw_en = 1'b0;
        // Software writes; while a slave command runs, channel writes are refused.
        if (wr && paddr == A_STAT) begin
            {zero_d, serr_d, cerr_d, ill_d} = 4'h0;
        end
        if (wr && paddr[7:6] == R_TXB) begin
            tw_en = 1'b1;
        end
        if (wr && st_q != S_IDLE && (paddr == A_CTRL || paddr == A_DATA || paddr == A_RXGO
                                     || paddr == A_SEQ || paddr == A_CMD)) begin
            ill_d = 1'b1;
        end else if (wr) begin
            case (paddr)
                A_CTRL: begin
                    newm  = csq_mode_t'(pwdata[1:0]);
                    tim_d = pwdata[F_TIM];
                end
                A_DATA: begin
                    if (mode_q == M_TX || mode_q == M_TRX) begin
                        ld = 1'b1; ldb = pwdata[7:0]; cnt_d = 8'h01; hnd_d = H_SINGLE;
                    end else begin
                        ill_d = 1'b1;
                    end
                end
                A_RXGO: begin
                    if (mode_q == M_RX || mode_q == M_TRX) begin
                        ld = 1'b1; ldb = DUMMY; cnt_d = 8'h01; hnd_d = H_SINGLE;
                    end else begin
                        ill_d = 1'b1;
                    end
                end
                A_SEQ: begin
                    go  = pwdata[F_KIND +: 2] != 2'h0;
                    ill_d = ill_q | ~go;
                    gk  = csq_mode_t'(pwdata[F_KIND +: 2]);
                    gn  = pwdata[7:0];
                    gtp = pwdata[F_TXP +: AW];
                    grp = pwdata[F_RXP +: AW];
                end
                A_CMD: begin
                    op_d  = csq_op_t'(pwdata[1:0]);
                    sel_d = pwdata[F_SEL];
                    csn_d = pwdata[F_SEL] ? 2'h1 : 2'h2;
                    tmo_d = 32'h0;
                    st_d  = S_SEL;
                end
                default: begin
                end
            endcase
        end
        // Interrupt dispatch to the handler of the running transfer.
        if (irq_q) begin
            case (hnd_q)
                H_SINGLE: begin
                    holdrx_d = rx_q; cnt_d = 8'h00; rxclr = 1'b1;
                end
                H_RXNEXT: begin
                    rw_en = 1'b1; rxp_d = rxp_q + AW'(1); cnt_d = cnt_q - 8'h01; rxclr = 1'b1;
                    if (cnt_q >= 8'h02) begin
                        ld = 1'b1; ldb = DUMMY;
                    end
                    if (cnt_q <= 8'h02) begin
                        tim_d = 1'b0;
                    end
                end
                H_TXNEXT, H_TRXNEXT: begin
                    if (hnd_q == H_TRXNEXT && rxr_q) begin
                        rw_en = 1'b1; rxp_d = rxp_q + AW'(1); rxclr = 1'b1;
                    end
                    if (cnt_q == 8'h01) begin
                        tim_d = 1'b0;
                        hnd_d = (hnd_q == H_TXNEXT) ? H_TXEND : H_TRXEND;
                    end else begin
                        cnt_d = cnt_q - 8'h01; ld = 1'b1; ldb = tbuf[txp_q]; txp_d = txp_q + AW'(1);
                    end
                end
                H_TRXEND: begin
                    rw_en = 1'b1; rxp_d = rxp_q + AW'(1); rxclr = 1'b1; cnt_d = 8'h00;
                end
                default: begin
                    cnt_d = 8'h00;
                end
            endcase
        end
        // Slave command sequencer.
        case (st_q)
            S_SEL: begin
                if (!busy_s) begin
                    newm = M_TRX; ld = 1'b1; cnt_d = 8'h01; hnd_d = H_SINGLE; st_d = S_CMD;
                    case (op_q)
                        O_STS:   ldb = CMD_STS;
                        O_TX:    ldb = CMD_TX;
                        O_RX:    ldb = CMD_RX;
                        default: ldb = CMD_TRX;
                    endcase
                end else if (tmo_q == 32'(TMO_CYC - 1)) begin
                    csn_d = CSN_RST; cerr_d = 1'b1; st_d = S_IDLE;
                end else begin
                    tmo_d = tmo_q + 32'h1;
                end
            end
            S_CMD: begin
                if (cnt_q == 8'h00) begin
                    st_d = S_XFER;
                    case (op_q)
                        O_STS: begin
                            ld = 1'b1; cnt_d = 8'h01; st_d = S_ST1;
                        end
                        O_TX: begin
                            go = 1'b1; gk = M_TX; gn = cur_rx;
                        end
                        O_RX: begin
                            go = 1'b1; gk = M_RX; gn = cur_tx;
                        end
                        default: begin
                            if (cur_tx == cur_rx) begin
                                go = 1'b1; gk = M_TRX; gn = cur_tx;
                            end else begin
                                cerr_d = 1'b1; st_d = S_DONE;
                            end
                        end
                    endcase
                end
            end
            S_ST1: begin
                if (cnt_q == 8'h00) begin
                    ld = 1'b1; cnt_d = 8'h01; st_d = S_ST2;
                    if (sel_q) slave_count_second_d[15:8] = holdrx_q;
                    else slave_count_first_d[15:8] = holdrx_q;
                end
            end
            S_ST2: begin
                if (cnt_q == 8'h00) begin
                    st_d = S_DONE;
                    if (sel_q) slave_count_second_d[7:0] = holdrx_q;
                    else slave_count_first_d[7:0] = holdrx_q;
                    if (holdrx_q > 8'(DEPTH) || cur_tx > 8'(DEPTH)) begin
                        cerr_d = 1'b1;
                    end
                end
            end
            S_XFER: begin
                if (cnt_q == 8'h00) st_d = S_DONE;
            end
            S_DONE: begin
                csn_d = CSN_RST; st_d = S_IDLE;
            end
            default: begin
            end
        endcase
        // Continuous start, shared by software and the sequencer.
        if (go) begin
            if (gn == 8'h00) begin
                zero_d = 1'b1;
            end else begin
                // A received flag left over from a transmit-only run would otherwise store a stale byte.
                newm = gk; cnt_d = gn; rxp_d = grp; txp_d = gtp; ld = 1'b1; rxclr = 1'b1;
                if (gk == M_RX) begin
                    ldb = DUMMY; hnd_d = H_RXNEXT;
                end else begin
                    ldb = tbuf[gtp]; txp_d = gtp + AW'(1); chk_d = 1'b1;
                    hnd_d = (gn >= 8'h02) ? ((gk == M_TX) ? H_TXNEXT : H_TRXNEXT)
                                          : ((gk == M_TX) ? H_TXEND : H_TRXEND);
                end
            end
        end
        chmode = newm != mode_q;
        if (chmode) begin
            abort = 1'b1; mode_d = newm; tim_d = 1'b0;
        end
        if (go && gn >= 8'h02 && gk != M_RX) tim_d = 1'b1;
        if (chk_q && !(run_q || hv_q)) serr_d = 1'b1;
    end

    // Read mux; data and error are registered in the setup phase.
    always_comb begin
        bad = 1'b0;
        case (paddr)
            A_CTRL:  rd = {29'h0, tim_q, mode_q};
            A_STAT:  rd = {17'h0, st_q != S_IDLE, ill_q, cerr_q, serr_q, zero_q, run_q | hv_q,
                           cnt_q == 8'h00, cnt_q};
            A_HOLD:  rd = {24'h0, holdrx_q};
            A_SLV:   rd = {slave_count_second_q, slave_count_first_q};
            A_DATA, A_RXGO, A_SEQ, A_CMD: rd = 32'h0;
            default: begin
                rd  = 32'h0;
                bad = 1'b1;
                if (paddr[7:6] == R_TXB && paddr[1:0] == 2'h0 && {1'b0, paddr[5:2]} < 5'(DEPTH)) begin
                    rd = {24'h0, tbuf[paddr[2 +: AW]]}; bad = 1'b0;
                end
                if (paddr[7:6] == R_RXB && paddr[1:0] == 2'h0 && {1'b0, paddr[5:2]} < 5'(DEPTH)) begin
                    rd = {24'h0, rbuf[paddr[2 +: AW]]}; bad = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk) begin
        if (tw_en) tbuf[paddr[2 +: AW]] <= pwdata[7:0];
        if (rw_en) rbuf[rxp_q] <= rx_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= 8'h00; hold_q <= 8'h00; rx_q <= 8'h00; div_q <= 8'h00; bit_q <= 3'h0;
            run_q <= 1'b0; hv_q <= 1'b0; sck_q <= 1'b1; mosi_q <= 1'b1; rxr_q <= 1'b0; irq_q <= 1'b0;
            mode_q <= M_OFF; tim_q <= 1'b0; hnd_q <= H_SINGLE; cnt_q <= 8'h00; holdrx_q <= 8'h00;
            txp_q <= '0; rxp_q <= '0; chk_q <= 1'b0; st_q <= S_IDLE; op_q <= O_STS; sel_q <= 1'b0;
            csn_q <= CSN_RST; tmo_q <= 32'h0; zero_q <= 1'b0; serr_q <= 1'b0; cerr_q <= 1'b0;
            ill_q <= 1'b0; slave_count_first_q <= 16'h0; slave_count_second_q <= 16'h0;
            prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
        end else begin
            sh_q <= sh_d; hold_q <= hold_d; rx_q <= rx_d; div_q <= div_d; bit_q <= bit_d;
            run_q <= run_d; hv_q <= hv_d; sck_q <= sck_d; mosi_q <= mosi_d; rxr_q <= rxr_d; irq_q <= irq_d;
            mode_q <= mode_d; tim_q <= tim_d; hnd_q <= hnd_d; cnt_q <= cnt_d; holdrx_q <= holdrx_d;
            txp_q <= txp_d; rxp_q <= rxp_d; chk_q <= chk_d; st_q <= st_d; op_q <= op_d; sel_q <= sel_d;
            csn_q <= csn_d; tmo_q <= tmo_d; zero_q <= zero_d; serr_q <= serr_d; cerr_q <= cerr_d;
            ill_q <= ill_d; slave_count_first_q <= slave_count_first_d;
            slave_count_second_q <= slave_count_second_d;
            pready  <= psel & ~penable;
            prdata  <= (psel & ~penable) ? rd : prdata;
            pslverr <= psel & ~penable & bad;
        end
    end

    assign sck          = sck_q;
    assign mosi         = mosi_q;
    assign cs_n         = csn_q;
    assign transfer_irq = irq_q;
endmodule
`default_nettype wire

// File: src/csq_pkg.sv
package csq_pkg;
    // Register byte offsets.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_RXGO = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_HOLD = 8'h10;
    localparam logic [7:0] A_SEQ  = 8'h14;
    localparam logic [7:0] A_CMD  = 8'h18;
    localparam logic [7:0] A_SLV  = 8'h1C;
    localparam logic [1:0] R_TXB  = 2'h1;
    localparam logic [1:0] R_RXB  = 2'h2;
    // Field positions.
    localparam int F_TIM  = 2;
    localparam int F_KIND = 8;
    localparam int F_TXP  = 12;
    localparam int F_RXP  = 16;
    localparam int F_SEL  = 2;
    // Values.
    localparam logic [7:0] DUMMY   = 8'hFF;
    localparam logic [7:0] CMD_STS = 8'h01;
    localparam logic [7:0] CMD_TX  = 8'h02;
    localparam logic [7:0] CMD_RX  = 8'h03;
    localparam logic [7:0] CMD_TRX = 8'h04;
    localparam logic [1:0] CSN_RST = 2'h3;
    // Timing.
    localparam int CLK_MHZ      = 200;
    localparam int BUSY_TMO_US  = 1000;
    localparam int BUSY_TMO_CYC = BUSY_TMO_US * CLK_MHZ;
    localparam int SCK_HALF     = 4;
    typedef enum logic [1:0] {M_OFF, M_TX, M_RX, M_TRX} csq_mode_t;
    typedef enum logic [1:0] {O_STS, O_TX, O_RX, O_TRX} csq_op_t;
    typedef enum logic [2:0] {H_SINGLE, H_RXNEXT, H_TXNEXT, H_TXEND, H_TRXNEXT, H_TRXEND} csq_hnd_t;
    typedef enum logic [2:0] {S_IDLE, S_SEL, S_CMD, S_ST1, S_ST2, S_XFER, S_DONE} csq_st_t;
endpackage
